// *** pte_read_error_reporting.sv ***
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Unrecoverable PTE read error sets the PTE read error status flag.
// - Such an error aborts the translation-buffer miss in progress.
// - Execution-unit read reference: exactly one retry before machine check.
// - Retry forces the memory-fault routine that probes the address.
// - Probe error raises machine check; success restarts the stream.
// - A repeated error sets the lost-error bit of the holding register.
// - Write reference: set error-on-write flag, discard write data.
// - Write-case machine check is raised at once, not at a boundary.
// - String instruction: frame pc is next, saved counter is current.
// - Otherwise the saved counter is undefined; software must ignore it.
// - Return-target fetch with first part done: frame pc is the target.
// - Uncorrectable ECC fill latches fill address and syndrome.
// - Fill error counts only for backup-cache block or locked fills.
// - Cache-acknowledge hard error also posts a soft error interrupt.
module pte_read_error_reporting
    import pte_err_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_pte_err,
    input wire pte_report_t i_report,
    input wire logic [ADDR_W-1:0] i_fill_addr,
    input wire logic [SYND_W-1:0] i_fill_syndrome,
    input wire logic [ADDR_W-1:0] i_cur_pc,
    input wire logic [ADDR_W-1:0] i_next_pc,
    input wire logic [ADDR_W-1:0] i_ret_target_pc,
    input wire logic i_probe_done,
    input wire logic i_instr_boundary,
    input wire logic [REG_AW-1:0] i_addr,
    input wire logic [31:0] i_wr_data,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    output logic [31:0] o_rd_data,
    output logic o_tb_miss_abort,
    output logic o_force_mm_fault,
    output logic o_machine_check,
    output logic o_restart_stream,
    output logic o_discard_write,
    output logic o_soft_error_irq,
    output frame_t o_frame
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PROBE_WAIT,
        ST_BOUNDARY_WAIT
    } state_t;

    state_t state_reg;
    state_t state_next;
    logic pte_read_error_flag;
    logic pte_error_on_write_flag;
    logic fill_ecc_flag;
    logic interface_hard_error_flag;
    logic second_fill_error_flag;
    logic second_interface_error_flag;
    logic retry_en_reg;
    logic [ADDR_W-1:0] fill_addr;
    logic [SYND_W-1:0] fill_synd;
    logic ecc_err;
    logic cack_err;
    logic err_event;
    logic start_event;
    logic go_probe;
    logic mchk_now;
    logic restart_now;
    logic [31:0] proc_status;
    logic [31:0] bus_if_status;

    // Write-one-to-clear strobe for one register bit
    function automatic logic w1c(input logic [REG_AW-1:0] ofs,
        input int bit_i);
        w1c = i_wr_en && (i_addr == ofs) && i_wr_data[bit_i];
    endfunction : w1c

    ////////////////////////////////////////////////////////////////////////
    // Error qualification
    assign ecc_err = i_report.fill_uncorrectable
        && i_report.bcache_block_fill;
    assign cack_err = i_report.cache_ack_hard;
    assign err_event = i_pte_err && (ecc_err || cack_err);
    assign start_event = err_event && (state_reg == ST_IDLE);
    assign go_probe = start_event && i_report.ebox_ref
        && !i_report.is_write && retry_en_reg;

    ////////////////////////////////////////////////////////////////////////
    // Sequencing of probe retry, stream restart and machine check
    always_comb begin
        state_next = state_reg;
        mchk_now = 1'b0;
        restart_now = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (start_event) begin
                    if (i_report.is_write) begin
                        mchk_now = 1'b1;
                    end else if (go_probe) begin
                        state_next = ST_PROBE_WAIT;
                    end else begin
                        state_next = ST_BOUNDARY_WAIT;
                    end
                end
            end
            ST_PROBE_WAIT: begin
                if (err_event) begin
                    mchk_now = 1'b1;
                    state_next = ST_IDLE;
                end else if (i_probe_done) begin
                    restart_now = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            ST_BOUNDARY_WAIT: begin
                if (i_instr_boundary) begin
                    mchk_now = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event pulses toward the memory and execution units
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            o_tb_miss_abort <= 1'b0;
            o_force_mm_fault <= 1'b0;
            o_machine_check <= 1'b0;
            o_restart_stream <= 1'b0;
            o_discard_write <= 1'b0;
            o_soft_error_irq <= 1'b0;
        end else begin
            o_tb_miss_abort <= err_event;
            o_force_mm_fault <= go_probe;
            o_machine_check <= mchk_now;
            o_restart_stream <= restart_now;
            o_discard_write <= err_event && i_report.is_write;
            o_soft_error_irq <= err_event && cack_err;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Processor status flags, sticky, set wins over clear
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            pte_read_error_flag <= 1'b0;
            pte_error_on_write_flag <= 1'b0;
        end else begin
            if (err_event) begin
                pte_read_error_flag <= 1'b1;
            end else if (w1c(OFS_PROC_STATUS, PS_PTE_READ_ERR_BIT)) begin
                pte_read_error_flag <= 1'b0;
            end
            if (err_event && i_report.is_write) begin
                pte_error_on_write_flag <= 1'b1;
            end else if (w1c(OFS_PROC_STATUS, PS_PTE_ERR_WR_BIT)) begin
                pte_error_on_write_flag <= 1'b0;
            end
        end
    end

    // Bus interface status flags with lost-error bits
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            fill_ecc_flag <= 1'b0;
            interface_hard_error_flag <= 1'b0;
            second_fill_error_flag <= 1'b0;
            second_interface_error_flag <= 1'b0;
        end else begin
            if (err_event && ecc_err) begin
                fill_ecc_flag <= 1'b1;
            end else if (w1c(OFS_BUS_IF_STATUS, BS_FILL_ECC_BIT)) begin
                fill_ecc_flag <= 1'b0;
            end
            if (err_event && cack_err) begin
                interface_hard_error_flag <= 1'b1;
            end else if (w1c(OFS_BUS_IF_STATUS, BS_IF_HARD_BIT)) begin
                interface_hard_error_flag <= 1'b0;
            end
            if (err_event && ecc_err && fill_ecc_flag) begin
                second_fill_error_flag <= 1'b1;
            end else if (w1c(OFS_BUS_IF_STATUS, BS_SECOND_FILL_BIT)) begin
                second_fill_error_flag <= 1'b0;
            end
            if (err_event && cack_err && interface_hard_error_flag) begin
                second_interface_error_flag <= 1'b1;
            end else if (w1c(OFS_BUS_IF_STATUS, BS_SECOND_IF_BIT)) begin
                second_interface_error_flag <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fill address and syndrome capture, locked by the fill flag
    pte_fill_capture u_capture (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_capture(err_event && ecc_err),
        .i_locked(fill_ecc_flag),
        .i_addr(i_fill_addr),
        .i_syndrome(i_fill_syndrome),
        .o_addr(fill_addr),
        .o_syndrome(fill_synd)
    );

    ////////////////////////////////////////////////////////////////////////
    // Machine-check frame counters taken at the first report
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            o_frame <= '0;
        end else if (start_event) begin
            if (i_report.ebox_ref && i_report.in_string_instr) begin
                o_frame.pc <= i_next_pc;
                o_frame.saved <= i_cur_pc;
            end else if (!i_report.ebox_ref && i_report.ret_target_fetch) begin
                o_frame.pc <= i_ret_target_pc;
                o_frame.saved <= ADDR_RST;
            end else begin
                o_frame.pc <= i_cur_pc;
                o_frame.saved <= ADDR_RST;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            retry_en_reg <= CTL_RETRY_EN_RST;
        end else if (i_wr_en && i_addr == OFS_CONTROL) begin
            retry_en_reg <= i_wr_data[CTL_RETRY_EN_BIT];
        end
    end

    // Status words
    always_comb begin
        proc_status = '0;
        proc_status[PS_PTE_READ_ERR_BIT] = pte_read_error_flag;
        proc_status[PS_PTE_ERR_WR_BIT] = pte_error_on_write_flag;
        bus_if_status = '0;
        bus_if_status[BS_FILL_ECC_BIT] = fill_ecc_flag;
        bus_if_status[BS_IF_HARD_BIT] = interface_hard_error_flag;
        bus_if_status[BS_SECOND_FILL_BIT] = second_fill_error_flag;
        bus_if_status[BS_SECOND_IF_BIT] = second_interface_error_flag;
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rd_data <= 32'h0000_0000;
        end else if (i_rd_en) begin
            case (i_addr)
                OFS_PROC_STATUS: o_rd_data <= proc_status;
                OFS_BUS_IF_STATUS: o_rd_data <= bus_if_status;
                OFS_FILL_ADDR: o_rd_data <= fill_addr;
                OFS_FILL_SYND: o_rd_data <= {24'h00_0000, fill_synd};
                OFS_CONTROL: o_rd_data <= {31'h0000_0000, retry_en_reg};
                OFS_FRAME_PC: o_rd_data <= o_frame.pc;
                OFS_FRAME_SAVED: o_rd_data <= o_frame.saved;
                default: o_rd_data <= 32'h0000_0000;
            endcase
        end else begin
            o_rd_data <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_flag_set;
        @(posedge i_core_clk) disable iff (i_reset)
        err_event |=> pte_read_error_flag && o_tb_miss_abort;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("PTE read error flag or abort missing");

    property p_abort_only_on_err;
        @(posedge i_core_clk) disable iff (i_reset)
        o_tb_miss_abort |-> $past(err_event);
    endproperty
    a_abort_only_on_err: assert property (p_abort_only_on_err)
        else $error("Miss abort without error");

    property p_single_probe;
        @(posedge i_core_clk) disable iff (i_reset)
        o_force_mm_fault |-> (state_reg == ST_PROBE_WAIT)
            ##1 !o_force_mm_fault;
    endproperty
    a_single_probe: assert property (p_single_probe)
        else $error("Probe forced without waiting for it");

    property p_probe_fail_mchk;
        @(posedge i_core_clk) disable iff (i_reset)
        (state_reg == ST_PROBE_WAIT && err_event) |=>
            o_machine_check && !o_restart_stream && state_reg == ST_IDLE;
    endproperty
    a_probe_fail_mchk: assert property (p_probe_fail_mchk)
        else $error("Repeated probe error gave no machine check");

    property p_lost_error;
        @(posedge i_core_clk) disable iff (i_reset)
        (err_event && cack_err && interface_hard_error_flag) |=>
            second_interface_error_flag;
    endproperty
    a_lost_error: assert property (p_lost_error)
        else $error("Lost error bit not set");

    property p_write_now;
        @(posedge i_core_clk) disable iff (i_reset)
        (start_event && i_report.is_write) |=>
            o_machine_check && o_discard_write && pte_error_on_write_flag;
    endproperty
    a_write_now: assert property (p_write_now)
        else $error("Write error not reported at once");

    property p_string_frame;
        @(posedge i_core_clk) disable iff (i_reset)
        (start_event && i_report.ebox_ref && i_report.in_string_instr) |=>
            o_frame.pc == $past(i_next_pc) && o_frame.saved == $past(i_cur_pc);
    endproperty
    a_string_frame: assert property (p_string_frame)
        else $error("String instruction frame counters wrong");

    property p_soft_irq;
        @(posedge i_core_clk) disable iff (i_reset)
        (err_event && cack_err) |=> o_soft_error_irq ##0 o_tb_miss_abort;
    endproperty
    a_soft_irq: assert property (p_soft_irq)
        else $error("Soft error interrupt not posted");

    property p_sticky;
        @(posedge i_core_clk) disable iff (i_reset)
        (pte_read_error_flag && !(i_wr_en && i_addr == OFS_PROC_STATUS
            && i_wr_data[PS_PTE_READ_ERR_BIT])) |=> pte_read_error_flag;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("Error flag dropped without clear");

endmodule : pte_read_error_reporting
`default_nettype wire

// *** pte_err_pkg.sv ***
`default_nettype none
package pte_err_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int ADDR_W = 32;
    localparam int SYND_W = 8;
    localparam int REG_AW = 8;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [REG_AW-1:0] OFS_PROC_STATUS = 8'h00;
    localparam logic [REG_AW-1:0] OFS_BUS_IF_STATUS = 8'h04;
    localparam logic [REG_AW-1:0] OFS_FILL_ADDR = 8'h08;
    localparam logic [REG_AW-1:0] OFS_FILL_SYND = 8'h0C;
    localparam logic [REG_AW-1:0] OFS_CONTROL = 8'h10;
    localparam logic [REG_AW-1:0] OFS_FRAME_PC = 8'h14;
    localparam logic [REG_AW-1:0] OFS_FRAME_SAVED = 8'h18;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int PS_PTE_READ_ERR_BIT = 0;
    localparam int PS_PTE_ERR_WR_BIT = 1;
    localparam int BS_FILL_ECC_BIT = 0;
    localparam int BS_IF_HARD_BIT = 1;
    localparam int BS_SECOND_FILL_BIT = 2;
    localparam int BS_SECOND_IF_BIT = 3;
    localparam int CTL_RETRY_EN_BIT = 0;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic CTL_RETRY_EN_RST = 1'b1;
    localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
    localparam logic [SYND_W-1:0] SYND_RST = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Error report from the memory unit for one page-table-entry read
    typedef struct packed {
        logic fill_uncorrectable; // Multi-bit ECC error on fill data
        logic bcache_block_fill; // Fill from backup cache, block read or lock
        logic cache_ack_hard; // Cache acknowledge hard error
        logic ebox_ref; // Original reference from execution unit
        logic is_write; // Original reference is a write
        logic in_string_instr; // Inside an interruptible string instr
        logic ret_target_fetch; // Opcode fetch at return target, part done
    } pte_report_t;

    // Stack-frame counters
    typedef struct packed {
        logic [ADDR_W-1:0] pc;
        logic [ADDR_W-1:0] saved;
    } frame_t;

endpackage : pte_err_pkg
`default_nettype wire

// *** pte_fill_capture.sv ***
`timescale 1ns/1ps
`default_nettype none
module pte_fill_capture
    import pte_err_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_capture,
    input wire logic i_locked,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [SYND_W-1:0] i_syndrome,
    output logic [ADDR_W-1:0] o_addr,
    output logic [SYND_W-1:0] o_syndrome
);

    ////////////////////////////////////////////////////////////////////////
    // First report is kept until software releases the lock
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            o_addr <= ADDR_RST;
            o_syndrome <= SYND_RST;
        end else if (i_capture && !i_locked) begin
            o_addr <= i_addr;
            o_syndrome <= i_syndrome;
        end
    end

endmodule : pte_fill_capture
`default_nettype wire

// *** pte_read_error_reporting_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module pte_read_error_reporting_tb
    import pte_err_pkg::*;
();

    ////////////////////////////////////////////////////////////////////////
    // Report codes: fill, bcache, cack, ebox, write, string, ret
    localparam pte_report_t R_CACK_EBOX = 7'h18;
    localparam pte_report_t R_FILL_STR = 7'h6A;
    localparam pte_report_t R_FILL_NOBC = 7'h48;
    localparam pte_report_t R_CACK_WR = 7'h1C;
    localparam pte_report_t R_CACK_RET = 7'h11;
    localparam logic [31:0] CUR_PC = 32'h0000_1000;
    localparam logic [31:0] NEXT_PC = 32'h0000_1004;
    localparam logic [31:0] RET_PC = 32'h0000_2000;

    logic core_clk;
    logic reset;
    logic pte_err;
    pte_report_t report;
    logic [ADDR_W-1:0] fill_addr;
    logic [SYND_W-1:0] fill_synd;
    logic probe_done;
    logic boundary;
    logic [REG_AW-1:0] addr;
    logic [31:0] wr_data;
    logic wr_en;
    logic rd_en;
    logic [31:0] rd_data;
    logic abort, force_mm, mchk, restart, discard, soft_irq;
    frame_t frame;
    int miscompares = 0;
    int n_checks = 0;

    pte_read_error_reporting u_pte_read_error_reporting (
        .i_core_clk(core_clk), .i_reset(reset), .i_pte_err(pte_err),
        .i_report(report), .i_fill_addr(fill_addr),
        .i_fill_syndrome(fill_synd), .i_cur_pc(CUR_PC),
        .i_next_pc(NEXT_PC), .i_ret_target_pc(RET_PC),
        .i_probe_done(probe_done), .i_instr_boundary(boundary),
        .i_addr(addr), .i_wr_data(wr_data), .i_wr_en(wr_en),
        .i_rd_en(rd_en), .o_rd_data(rd_data), .o_tb_miss_abort(abort),
        .o_force_mm_fault(force_mm), .o_machine_check(mchk),
        .o_restart_stream(restart), .o_discard_write(discard),
        .o_soft_error_irq(soft_irq), .o_frame(frame)
    );

    ////////////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare and verdict tasks
    task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_pulses(input logic [5:0] exp);
        logic [5:0] got;
        got = {abort, force_mm, mchk, restart, discard, soft_irq};
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_pulses

    task automatic complete_run();
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    ////////////////////////////////////////////////////////////////////////
    // Register port and event stimulus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1;
        chk_val({32'h0000_0000, rd_data}, {32'h0000_0000, exp});
    endtask : rd_chk

    // One-cycle event, pulses checked in the answering cycle
    task automatic stim(input logic e, input pte_report_t r, input logic p,
                        input logic b, input logic [5:0] exp);
        @(posedge core_clk);
        pte_err <= e;
        report <= r;
        probe_done <= p;
        boundary <= b;
        @(posedge core_clk);
        pte_err <= 1'b0;
        probe_done <= 1'b0;
        boundary <= 1'b0;
        #1;
        chk_pulses(exp);
    endtask : stim

    task automatic clr_flags();
        wr(OFS_PROC_STATUS, 32'h0000_0003);
        wr(OFS_BUS_IF_STATUS, 32'h0000_000F);
    endtask : clr_flags

    ////////////////////////////////////////////////////////////////////////
    // Watchdog, far beyond the roughly 110 cycles of the tests
    initial begin
        #50000;
        miscompares++;
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        reset = 1'b1;
        pte_err = 1'b0;
        report = '0;
        fill_addr = 32'h0000_0000;
        fill_synd = 8'h00;
        probe_done = 1'b0;
        boundary = 1'b0;
        addr = 8'h00;
        wr_data = 32'h0000_0000;
        wr_en = 1'b0;
        rd_en = 1'b0;
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        // Reset values and an unmapped place
        rd_chk(OFS_CONTROL, 32'h0000_0001);
        rd_chk(OFS_PROC_STATUS, 32'h0000_0000);
        rd_chk(OFS_BUS_IF_STATUS, 32'h0000_0000);
        wr(8'h1C, 32'hFFFF_FFFF);
        rd_chk(8'h1C, 32'h0000_0000);
        // Ebox cack read: abort, forced probe, soft irq
        stim(1'b1, R_CACK_EBOX, 1'b0, 1'b0, 6'h31);
        chk_val(frame, {CUR_PC, 32'h0000_0000});
        rd_chk(OFS_PROC_STATUS, 32'h0000_0001);
        rd_chk(OFS_BUS_IF_STATUS, 32'h0000_0002);
        // Probe repeats the error: machine check, lost bit
        stim(1'b1, R_CACK_EBOX, 1'b0, 1'b0, 6'h29);
        rd_chk(OFS_BUS_IF_STATUS, 32'h0000_000A);
        rd_chk(OFS_PROC_STATUS, 32'h0000_0001);
        clr_flags();
        rd_chk(OFS_PROC_STATUS, 32'h0000_0000);
        rd_chk(OFS_BUS_IF_STATUS, 32'h0000_0000);
        // Fill error in a string instruction, probe succeeds
        @(posedge core_clk);
        fill_addr <= 32'h00AB_CD40;
        fill_synd <= 8'h5A;
        stim(1'b1, R_FILL_STR, 1'b0, 1'b0, 6'h30);
        chk_val(frame, {NEXT_PC, CUR_PC});
        stim(1'b0, R_FILL_STR, 1'b1, 1'b0, 6'h04);
        rd_chk(OFS_FILL_ADDR, 32'h00AB_CD40);
        rd_chk(OFS_FILL_SYND, 32'h0000_005A);
        rd_chk(OFS_BUS_IF_STATUS, 32'h0000_0001);
        // Second fill error keeps the first capture
        @(posedge core_clk);
        fill_addr <= 32'h0012_3480;
        fill_synd <= 8'hC3;
        stim(1'b1, R_FILL_STR, 1'b0, 1'b0, 6'h30);
        stim(1'b0, R_FILL_STR, 1'b1, 1'b0, 6'h04);
        rd_chk(OFS_BUS_IF_STATUS, 32'h0000_0005);
        rd_chk(OFS_FILL_ADDR, 32'h00AB_CD40);
        rd_chk(OFS_FILL_SYND, 32'h0000_005A);
        clr_flags();
        // Fill error not from a backup-cache block fill is ignored
        stim(1'b1, R_FILL_NOBC, 1'b0, 1'b0, 6'h00);
        rd_chk(OFS_PROC_STATUS, 32'h0000_0000);
        // Write reference: immediate check, write data dropped
        stim(1'b1, R_CACK_WR, 1'b0, 1'b0, 6'h2B);
        rd_chk(OFS_PROC_STATUS, 32'h0000_0003);
        clr_flags();
        // Return-target fetch, first part done: check waits for boundary
        stim(1'b1, R_CACK_RET, 1'b0, 1'b0, 6'h21);
        stim(1'b0, R_CACK_RET, 1'b0, 1'b1, 6'h08);
        chk_val(frame, {RET_PC, 32'h0000_0000});
        rd_chk(OFS_FRAME_PC, RET_PC);
        rd_chk(OFS_FRAME_SAVED, 32'h0000_0000);
        clr_flags();
        // Retry disabled: Ebox reference goes straight to boundary wait
        wr(OFS_CONTROL, 32'h0000_0000);
        rd_chk(OFS_CONTROL, 32'h0000_0000);
        stim(1'b1, R_CACK_EBOX, 1'b0, 1'b0, 6'h21);
        stim(1'b0, R_CACK_EBOX, 1'b0, 1'b1, 6'h08);
        stim(1'b0, R_CACK_EBOX, 1'b0, 1'b0, 6'h00);
        complete_run();
    end

endmodule : pte_read_error_reporting_tb
`default_nettype wire
